// >>> hw/lcdbpv_defs.vh
// Constants for the loop-code monitor and violation injector.
// Assumes a 10 MHz system clock and classic Wishbone register access.
`ifndef LCDBPV_DEFS_VH
`define LCDBPV_DEFS_VH

// Register byte offsets.
`define LCDBPV_REG_CTRL    8'h00
`define LCDBPV_REG_STATUS  8'h04
`define LCDBPV_REG_IRQ     8'h08
`define LCDBPV_REG_MASK    8'h0c

// Control register fields.
`define LCDBPV_CTRL_SEL_LO   0
`define LCDBPV_CTRL_SEL_HI   1
`define LCDBPV_CTRL_USE_REG  2
`define LCDBPV_CTRL_RESET    32'h00000000

// Interrupt status bit positions.
`define LCDBPV_IRQ_SEEN_RISE  0
`define LCDBPV_IRQ_SEEN_FALL  1
`define LCDBPV_IRQ_LOOP_ON    2
`define LCDBPV_IRQ_LOOP_OFF   3
`define LCDBPV_IRQ_WIDTH      4

// Mode select encodings.
`define LCDBPV_MODE_OFF   2'b00
`define LCDBPV_MODE_UP    2'b01
`define LCDBPV_MODE_DOWN  2'b10
`define LCDBPV_MODE_AUTO  2'b11

// Loop patterns, carried right-aligned in a 5-bit field.
`define LCDBPV_PAT_UP     5'h01
`define LCDBPV_PAT_UP_LEN 3'd5
`define LCDBPV_PAT_DN     5'h01
`define LCDBPV_PAT_DN_LEN 3'd3

// Persistence time and clock rate.
`define LCDBPV_HOLD_SEC   5
`define LCDBPV_CLK_HZ     10000000

`endif

// >>> hw/lcdbpv_pattern_watch.v
// Pattern persistence detector for one repeating loop code.
// Assumes rx_bit_en marks each receive bit, already in the clk_sys domain.
`timescale 1ns/100ps
`default_nettype none
`include "lcdbpv_defs.vh"

module lcdbpv_pattern_watch #(
  parameter HOLD_CYCLES = 50000000
) (
  // Clock and reset.
  input  wire       clk_sys,
  input  wire       rst,
  // Pattern selection and restart.
  input  wire [4:0] pattern,
  input  wire [2:0] pat_len,
  input  wire       restart,
  // Receive bit stream.
  input  wire       rx_bit_en,
  input  wire       rx_bit,
  // Result.
  output reg        present,
  output reg        held
);

  reg [4:0]  hist;
  reg [2:0]  fill;
  reg [2:0]  phase;
  reg [31:0] count;
  wire [4:0] len_mask = (5'h1f >> (3'd5 - pat_len));
  wire [4:0] next_hist = {hist[3:0], rx_bit};
  // Bits after phase 0 are matched against the bit one period back; at phase 0 the window must equal the code, not a rotation of it.
  wire [2:0] lag = pat_len;
  wire       rot_ok = (fill >= pat_len) &&
                      ((({hist[3:0], rx_bit} & len_mask) == pattern) || (phase != 3'd0) ||
                       1'b0);
  reg        ph_ok;

  // Phase tracking: the window must align with the code once per period.
  always @* begin
    ph_ok = 1'b0;
    if (phase == 3'd0) begin
      ph_ok = ((next_hist & len_mask) == pattern);
    end else begin
      ph_ok = (hist[lag-3'd1] == rx_bit) || 1'b0;
    end
  end

  // Tracks whether the code is currently present and for how long.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hist    <= 5'h00;
      fill    <= 3'd0;
      phase   <= 3'd0;
      count   <= 32'h00000000;
      present <= 1'b0;
      held    <= 1'b0;
    end else if (restart) begin
      fill    <= 3'd0;
      phase   <= 3'd0;
      count   <= 32'h00000000;
      present <= 1'b0;
      held    <= 1'b0;
    end else if (rx_bit_en) begin
      hist <= next_hist;
      if (fill != 3'd7) begin
        fill <= fill + 3'd1;
      end
      // The fill count saturates, so compare against len-1 rather than adding one to it.
      if (fill < pat_len - 3'd1) begin
        phase <= 3'd0;
      end else if (ph_ok && rot_ok) begin
        present <= 1'b1;
        phase   <= (phase == pat_len - 3'd1) ? 3'd0 : phase + 3'd1;
      end else if (present || fill >= pat_len - 3'd1) begin
        // A break in the code restarts the measurement.
        present <= 1'b0;
        held    <= 1'b0;
        count   <= 32'h00000000;
        phase   <= 3'd0;
      end
    end else if (present && !held) begin
      // Persistence beyond the hold time raises held.
      if (count >= HOLD_CYCLES - 1) begin
        held <= 1'b1;
      end else begin
        count <= count + 32'h00000001;
      end
    end
  end

endmodule
`default_nettype wire

// >>> hw/lcdbpv_top.v
// Loop-code monitor with automatic remote loop-back and violation injector.
// Assumes classic Wishbone slave access; pins and tx_clock arrive asynchronous.
`timescale 1ns/100ps
`default_nettype none
`include "lcdbpv_defs.vh"

module lcdbpv_top #(
  parameter HOLD_CYCLES = `LCDBPV_HOLD_SEC * `LCDBPV_CLK_HZ
) (
  // Clock and reset.
  input  wire        clk_sys,
  input  wire        rst,
  // Wishbone slave.
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // Hardware-mode pins.
  input  wire        loop_watch_sel_hi,
  input  wire        loop_watch_sel_lo,
  input  wire        violation_inject_in,
  // Receive data, recovered bit with its clock.
  input  wire        rx_clock,
  input  wire        rx_data,
  // Transmit side.
  input  wire        tx_clock,
  input  wire        tx_qrss_on,
  input  wire        tx_single_rail,
  output reg         tx_violation,
  // Status outputs.
  output reg         loop_code_seen_out,
  output reg         remote_loopback,
  output wire        irq
);

  // Two-flop synchronisers; only stage two is read.
  reg [1:0] s_hi, s_lo, s_inj, s_rxc, s_rxd, s_txc;
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_hi  <= 2'b00;
      s_lo  <= 2'b00;
      s_inj <= 2'b00;
      s_rxc <= 2'b00;
      s_rxd <= 2'b00;
      s_txc <= 2'b00;
    end else begin
      s_hi  <= {s_hi[0], loop_watch_sel_hi};
      s_lo  <= {s_lo[0], loop_watch_sel_lo};
      s_inj <= {s_inj[0], violation_inject_in};
      s_rxc <= {s_rxc[0], rx_clock};
      s_rxd <= {s_rxd[0], rx_data};
      s_txc <= {s_txc[0], tx_clock};
    end
  end

  // Edge history of synchronised clocks and inject pin.
  reg rxc_d, txc_d, inj_samp;
  reg [31:0] ctrl;
  reg [`LCDBPV_IRQ_WIDTH-1:0] irq_stat, irq_mask;
  wire rx_bit_en = s_rxc[1] & ~rxc_d;
  wire tx_rise   = s_txc[1] & ~txc_d;

  // Mode comes from the pins unless software takes over.
  wire [1:0] mode = ctrl[`LCDBPV_CTRL_USE_REG] ?
                    {ctrl[`LCDBPV_CTRL_SEL_HI], ctrl[`LCDBPV_CTRL_SEL_LO]} : {s_hi[1], s_lo[1]};
  reg  [1:0] mode_d;
  wire mode_chg = (mode != mode_d);

  // Which code is watched: loop-down in manual down, or while looped back.
  wire watch_dn = (mode == `LCDBPV_MODE_DOWN) ||
                  ((mode == `LCDBPV_MODE_AUTO) && remote_loopback);
  reg  watch_dn_d;
  wire restart = mode_chg || (watch_dn != watch_dn_d) || (mode == `LCDBPV_MODE_OFF);
  wire present;
  wire held;

  lcdbpv_pattern_watch #(
    .HOLD_CYCLES (HOLD_CYCLES)
  ) u_watch (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .pattern   (watch_dn ? `LCDBPV_PAT_DN : `LCDBPV_PAT_UP),
    .pat_len   (watch_dn ? `LCDBPV_PAT_DN_LEN : `LCDBPV_PAT_UP_LEN),
    .restart   (restart),
    .rx_bit_en (rx_bit_en),
    .rx_bit    (s_rxd[1]),
    .present   (present),
    .held      (held)
  );

  // Detect and loop-back control per mode.
  reg next_seen, next_loop;
  always @* begin
    next_seen = loop_code_seen_out;
    next_loop = remote_loopback;
    case (mode)
      `LCDBPV_MODE_UP, `LCDBPV_MODE_DOWN: begin
        next_loop = 1'b0;
        next_seen = held & present & ~restart;
      end
      `LCDBPV_MODE_AUTO: begin
        if (mode_chg) begin
          next_seen = 1'b0;
          next_loop = 1'b0;
        end else if (!remote_loopback && held && !watch_dn_d) begin
          next_seen = 1'b1;
          next_loop = 1'b1;
        end else if (remote_loopback && held && watch_dn_d) begin
          next_seen = 1'b0;
          next_loop = 1'b0;
        end else begin
          next_seen = remote_loopback;
        end
      end
      default: begin
        next_seen = 1'b0;
        next_loop = 1'b0;
      end
    endcase
  end

  // Status flops and event history.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode_d             <= `LCDBPV_MODE_OFF;
      watch_dn_d         <= 1'b0;
      loop_code_seen_out <= 1'b0;
      remote_loopback    <= 1'b0;
      rxc_d              <= 1'b0;
      txc_d              <= 1'b0;
      inj_samp           <= 1'b0;
      tx_violation       <= 1'b0;
    end else begin
      mode_d             <= mode;
      watch_dn_d         <= watch_dn;
      loop_code_seen_out <= next_seen;
      remote_loopback    <= next_loop;
      rxc_d              <= s_rxc[1];
      txc_d              <= s_txc[1];
      tx_violation       <= 1'b0;
      if (tx_rise) begin
        // Inject pin sampled on each transmit clock rising edge.
        inj_samp <= s_inj[1];
        // One violation per 0-to-1 sample, only into QRSS or single-rail data.
        tx_violation <= s_inj[1] & ~inj_samp & (tx_qrss_on | tx_single_rail);
      end
    end
  end

  // Interrupt events from the detect and loop-back edges.
  wire [`LCDBPV_IRQ_WIDTH-1:0] events;
  assign events[`LCDBPV_IRQ_SEEN_RISE] = next_seen & ~loop_code_seen_out;
  assign events[`LCDBPV_IRQ_SEEN_FALL] = ~next_seen & loop_code_seen_out;
  assign events[`LCDBPV_IRQ_LOOP_ON]   = next_loop & ~remote_loopback;
  assign events[`LCDBPV_IRQ_LOOP_OFF]  = ~next_loop & remote_loopback;
  assign irq = |(irq_stat & irq_mask);

  // Wishbone slave: one wait state, ack for one cycle; sticky bits clear on read, set wins.
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire rd_irq = req & ~wb_we_i & (wb_adr_i == `LCDBPV_REG_IRQ);
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      ctrl     <= `LCDBPV_CTRL_RESET;
      irq_mask <= {`LCDBPV_IRQ_WIDTH{1'b0}};
      irq_stat <= {`LCDBPV_IRQ_WIDTH{1'b0}};
    end else begin
      wb_ack_o <= req;
      irq_stat <= (rd_irq ? {`LCDBPV_IRQ_WIDTH{1'b0}} : irq_stat) | events;
      if (req) begin
        wb_dat_o <= 32'h00000000;
        case (wb_adr_i)
          `LCDBPV_REG_CTRL: begin
            wb_dat_o <= {29'h0, ctrl[2:0]};
            if (wb_we_i && wb_sel_i[0]) begin
              ctrl <= {29'h0, wb_dat_i[2:0]};
            end
          end
          `LCDBPV_REG_STATUS: begin
            wb_dat_o <= {26'h0, mode, held, present, remote_loopback, loop_code_seen_out};
          end
          `LCDBPV_REG_IRQ: begin
            wb_dat_o <= {28'h0, irq_stat};
          end
          `LCDBPV_REG_MASK: begin
            wb_dat_o <= {28'h0, irq_mask};
            if (wb_we_i && wb_sel_i[0]) begin
              irq_mask <= wb_dat_i[`LCDBPV_IRQ_WIDTH-1:0];
            end
          end
          default: begin
            wb_dat_o <= 32'h00000000;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// >>> sim/lcdbpv_partner.sv
// Board model: free line clocks and the receive loop-code stream.
// Assumes the bench picks the stream: 0 all ones, 1 loop-up, 2 loop-down.
`timescale 1ns/100ps
`default_nettype none
module lcdbpv_partner (
  // Stream choice.
  input  wire logic [1:0] pat_sel,
  // Line side.
  output var  logic       rx_clock,
  output var  logic       rx_data,
  output var  logic       tx_clock
);
  int idx;
  // Line clocks run free, at phases unrelated to the system clock.
  initial begin
    idx = 0;
    rx_clock = 1'b0;
    rx_data = 1'b1;
    tx_clock = 1'b0;
    fork
      forever #400 rx_clock = ~rx_clock;
      #137 forever #300 tx_clock = ~tx_clock;
    join
  end
  // A new bit on the falling edge keeps it steady at the rising one.
  always @(negedge rx_clock) begin
    idx = (idx + 1) % ((pat_sel == 2'd2) ? 3 : 5);
    rx_data <= (pat_sel == 2'd0) || (idx == ((pat_sel == 2'd2) ? 2 : 4));
  end
endmodule
`default_nettype wire

// >>> sim/lcdbpv_props.sv
// Port checker for the loop-code monitor and violation injector.
// Assumes one clk_sys domain; mode pins reach the logic within a few cycles.
`timescale 1ns/100ps
`default_nettype none
module lcdbpv_props (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Bus handshake.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Pins and outputs.
  input wire logic loop_watch_sel_hi,
  input wire logic loop_watch_sel_lo,
  input wire logic violation_inject_in,
  input wire logic tx_qrss_on,
  input wire logic tx_single_rail,
  input wire logic tx_violation,
  input wire logic loop_code_seen_out,
  input wire logic remote_loopback
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [4:0] quiet;
  // Counts cycles since the inject pin last moved, saturating at the top.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      quiet <= 5'h00;
    end else if (violation_inject_in != $past(violation_inject_in)) begin
      quiet <= 5'h00;
    end else if (quiet != 5'h1f) begin
      quiet <= quiet + 5'h01;
    end
  end
  chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  chk_off_quiet: assert property ((!loop_watch_sel_hi && !loop_watch_sel_lo) [*6] |-> !loop_code_seen_out)
    else $error("detect while off");
  chk_leave_auto: assert property ((!(loop_watch_sel_hi && loop_watch_sel_lo)) [*6] |-> !remote_loopback)
    else $error("loopback outside auto");
  chk_lb_seen: assert property (remote_loopback |-> loop_code_seen_out) else $error("detect low in loopback");
  chk_lb_rise: assert property ($rose(remote_loopback) |-> $rose(loop_code_seen_out)) else $error("rise split");
  chk_lb_fall: assert property ($fell(remote_loopback) && loop_watch_sel_hi && loop_watch_sel_lo
    |-> $fell(loop_code_seen_out)) else $error("fall split");
  chk_viol_pulse: assert property (tx_violation |=> !tx_violation) else $error("violation too long");
  chk_viol_gate: assert property ((!tx_qrss_on && !tx_single_rail) [*6] |-> !tx_violation)
    else $error("violation while gated");
  chk_viol_idle: assert property (quiet == 5'h1f |-> !tx_violation) else $error("violation without edge");
  cover property ($rose(remote_loopback));
  cover property ($fell(remote_loopback));
  cover property (tx_violation);
endmodule
bind lcdbpv_top lcdbpv_props u_props (.clk_sys, .rst, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .loop_watch_sel_hi,
  .loop_watch_sel_lo, .violation_inject_in, .tx_qrss_on, .tx_single_rail, .tx_violation, .loop_code_seen_out,
  .remote_loopback);
`default_nettype wire

// >>> sim/test_loop_code_detect_bpv_insert.sv
// Self-checking bench for the loop-code monitor and violation injector.
// Assumes the board model makes the line clocks and the receive stream.
`timescale 1ns/100ps
`default_nettype none
module test_loop_code_detect_bpv_insert;
  logic        clk_sys, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, r;
  logic        loop_watch_sel_hi, loop_watch_sel_lo, violation_inject_in, tx_qrss_on, tx_single_rail;
  logic        rx_clock, rx_data, tx_clock, tx_violation, loop_code_seen_out, remote_loopback, irq;
  logic [1:0]  pat_sel;
  logic [31:0] exp_q[$];
  int          failures, total_checks, viol_cnt;
  lcdbpv_top #(.HOLD_CYCLES(200)) u_dut (.clk_sys, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .loop_watch_sel_hi, .loop_watch_sel_lo, .violation_inject_in, .rx_clock,
    .rx_data, .tx_clock, .tx_qrss_on, .tx_single_rail, .tx_violation, .loop_code_seen_out, .remote_loopback, .irq);
  lcdbpv_partner u_board (.pat_sel, .rx_clock, .rx_data, .tx_clock);
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk_pin(string n, logic e, logic g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s exp %b got %b", n, e, g);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // One classic cycle; it returns at the edge that sees ack, and gives up after 20 cycles to end a hang.
  task automatic wb(logic we, logic [7:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n == 20) begin
      failures++;
      finish_test();
    end
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask
  task automatic mode(logic [1:0] m, logic [1:0] p);
    @(posedge clk_sys);
    {loop_watch_sel_hi, loop_watch_sel_lo, pat_sel} <= {m, p};
  endtask
  task automatic wait_seen(logic v, int max);
    int n;
    n = 0;
    while (loop_code_seen_out !== v && n < max) begin
      @(posedge clk_sys);
      n++;
    end
    chk_pin("seen", v, loop_code_seen_out);
  endtask
  // The system clock, and a limit that cuts a hang short.
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial begin
    #2000000;
    failures++;
    finish_test();
  end
  // Takes the oldest expected word whenever read data is acknowledged; counts violations.
  always @(posedge clk_sys) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) chk("rdata", exp_q.pop_front(), wb_dat_o);
    if (tx_violation === 1'b1) viol_cnt++;
  end
  // Main sequence.
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, loop_watch_sel_hi, loop_watch_sel_lo, violation_inject_in} = 6'h00;
    {tx_qrss_on, tx_single_rail, pat_sel, wb_adr_i, wb_dat_i, wb_sel_i} = {44'h0, 4'hf};
    {failures, total_checks, viol_cnt} = 96'h0;
    rst = 1'b1;
    r = $urandom(18);
    cyc(10);
    rst <= 1'b0;
    chk_pin("loopback", 1'b0, remote_loopback);
    rd(8'h00, 32'h0);
    rd(8'h0c, 32'h0);
    r = $urandom & 32'h7;
    wb(1'b1, 8'h00, r);
    rd(8'h00, r);
    wb(1'b1, 8'h00, 32'h0);
    wb(1'b1, 8'h10, 32'hffffffff);
    rd(8'h10, 32'h0);
    for (int m = 1; m < 3; m++) begin
      mode(2'(m), 2'(m));
      cyc(120);
      mode(2'(m), 2'd0);
      cyc(40);
      mode(2'(m), 2'(m));
      cyc(150);
      chk_pin("seen", 1'b0, loop_code_seen_out);
      wait_seen(1'b1, 300);
      mode(2'(m), 2'd0);
      wait_seen(1'b0, 30);
    end
    mode(2'b00, 2'd1);
    cyc(400);
    chk_pin("seen", 1'b0, loop_code_seen_out);
    mode(2'b01, 2'd1);
    wait_seen(1'b1, 400);
    mode(2'b11, 2'd1);
    cyc(6);
    chk_pin("seen", 1'b0, loop_code_seen_out);
    wait_seen(1'b1, 400);
    chk_pin("loopback", 1'b1, remote_loopback);
    chk_pin("irq", 1'b0, irq);
    wb(1'b1, 8'h0c, 32'hf);
    cyc(1);
    chk_pin("irq", 1'b1, irq);
    rd(8'h08, 32'h7);
    cyc(2);
    chk_pin("irq", 1'b0, irq);
    mode(2'b11, 2'd0);
    cyc(300);
    chk_pin("seen", 1'b1, loop_code_seen_out);
    mode(2'b11, 2'd2);
    cyc(150);
    chk_pin("loopback", 1'b1, remote_loopback);
    wait_seen(1'b0, 300);
    chk_pin("loopback", 1'b0, remote_loopback);
    mode(2'b00, 2'd1);
    cyc(10);
    mode(2'b11, 2'd1);
    wait_seen(1'b1, 400);
    mode(2'b01, 2'd1);
    cyc(10);
    chk_pin("loopback", 1'b0, remote_loopback);
    for (int g = 0; g < 4; g++) begin
      {tx_qrss_on, tx_single_rail} <= 2'(g);
      viol_cnt = 0;
      repeat (3) begin
        cyc(12 + $urandom % 8);
        violation_inject_in <= 1'b1;
        cyc(12 + $urandom % 8);
        violation_inject_in <= 1'b0;
      end
      cyc(30);
      chk("violations", (g == 0) ? 32'd0 : 32'd3, viol_cnt);
    end
    finish_test();
  end
endmodule
`default_nettype wire
